/* pkg/pm_alias_cfg.svh */
// Constants for the power-management and command-alias preload block.
// Assumes inclusion by pm_alias_pkg users only; definitions only.
`ifndef PM_ALIAS_CFG_SVH
`define PM_ALIAS_CFG_SVH

// ----------------------------------------------------------------------------
// Configuration dword offsets
// ----------------------------------------------------------------------------
`define OFS_ALIAS_CTRL      8'h74
`define OFS_PM_CAP          8'h80
`define OFS_PM_DATA         8'h84

// ----------------------------------------------------------------------------
// Preload byte addresses
// ----------------------------------------------------------------------------
`define EE_PM_CAP_LO        8'h0a
`define EE_PM_DATA          8'h0d
`define EE_CTRL_LO          8'h0e
`define EE_CTRL_HI          8'h0f

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CAP_VER_LSB         16
`define CAP_VER_MSB         18
`define CAP_DSI_BIT         21
`define CAP_D1_BIT          25
`define CAP_D2_BIT          26
`define CAP_PME_LSB         27
`define CAP_PME_MSB         31
`define DATA_LSB            24
`define DATA_MSB            31
`define CTRL_LSB            1
`define CTRL_MSB            11

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_PM_VER          3'h2
`define RST_PM_DATA         8'h00
`define RST_CTRL            11'h000

// ----------------------------------------------------------------------------
// Bus command codes
// ----------------------------------------------------------------------------
`define CMD_MEM_RD          4'h6
`define CMD_MEM_WR          4'h7
`define CMD_MEM_RD_MULT     4'hc
`define CMD_MEM_RD_LINE     4'he
`define CMD_MEM_WR_INV      4'hf

`endif

/* pkg/pm_alias_pkg.sv */
// Types shared by the preload block and its alias decoder.
// Assumes pm_alias_cfg.svh is on the include path.
package pm_alias_pkg;

	// ------------------------------------------------------------------------
	// Control register fields, bit 11 down to bit 1
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic hold_pri;
		logic hold_sec;
		logic long_lock_req;
		logic wr_inv_dis_sec;
		logic wr_inv_dis_pri;
		logic rd_multi_sec;
		logic rd_multi_pri;
		logic wr_sec;
		logic rd_sec;
		logic wr_pri;
		logic rd_pri;
	} ctrl_s;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} cfg_req_s;

	typedef enum logic [1:0] {
		ST_LOAD  = 2'b01,
		ST_READY = 2'b10
	} load_state_e;

endpackage : pm_alias_pkg

/* tb/ee_image_model.sv */
// Preload image source that hands the loader one byte per strobe.
// Assumes a start pulse from the bench; bytes 0Ah to 0Fh go out in order.
`timescale 1ns/1ps

module ee_image_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic        slow,
	input  wire logic [47:0] image,
	output logic             ee_valid,
	output logic [7:0]       ee_addr,
	output logic [7:0]       ee_data,
	output logic             ee_done
);
	logic [2:0] idx;
	logic       run;
	logic       gap;

	// ------------------------------------------------------------------------
	// Byte sequencer
	// ------------------------------------------------------------------------
	// Address and data toggle between strobes so a stale byte never looks valid.
	always_ff @(posedge clk) begin
		ee_valid <= 1'b0;
		ee_done  <= 1'b0;
		ee_addr  <= ~ee_addr;
		ee_data  <= ~ee_data;
		if (rst) begin
			run     <= 1'b0;
			idx     <= 3'h0;
			gap     <= 1'b0;
			ee_addr <= 8'h00;
			ee_data <= 8'h00;
		end else if (start) begin
			run <= 1'b1;
			idx <= 3'h0;
			gap <= 1'b0;
		end else if (run && gap) begin
			gap <= 1'b0;
		end else if (run && idx == 3'h6) begin
			run     <= 1'b0;
			ee_done <= 1'b1;
		end else if (run) begin
			ee_valid <= 1'b1;
			ee_addr  <= 8'h0a + {5'h0, idx};
			ee_data  <= image[8*idx +: 8];
			idx      <= idx + 3'h1;
			gap      <= slow;
		end
	end
endmodule : ee_image_model

/* tb/tb.sv */
// Self-checking bench for the preload block fed by the image source model.
// Assumes the package and the constants header are compiled beforehand.
`timescale 1ns/1ps

module tb;
	logic                   clk;
	logic                   rst;
	logic                   start;
	logic                   slow;
	logic [47:0]            image;
	logic                   ee_valid;
	logic [7:0]             ee_addr;
	logic [7:0]             ee_data;
	logic                   ee_done;
	pm_alias_pkg::cfg_req_s cfg_req;
	logic [31:0]            cfg_rdata;
	logic                   cfg_ack;
	logic [3:0]             p_cmd;
	logic [3:0]             s_cmd;
	logic                   p_alias;
	logic                   s_alias;
	pm_alias_pkg::ctrl_s    ctrl;
	logic                   loaded;
	int                     miscompares;
	int                     checks;

	ee_image_model src (.clk(clk), .rst(rst), .start(start), .slow(slow), .image(image),
		.ee_valid(ee_valid), .ee_addr(ee_addr), .ee_data(ee_data), .ee_done(ee_done));

	eeprom_pm_alias_preload uut (.clk(clk), .rst(rst), .ee_valid(ee_valid), .ee_addr(ee_addr),
		.ee_data(ee_data), .ee_done(ee_done), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
		.cfg_ack(cfg_ack), .p_cmd(p_cmd), .s_cmd(s_cmd), .p_alias(p_alias), .s_alias(s_alias),
		.ctrl(ctrl), .loaded(loaded));

	// ------------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic finish_test;
		if (miscompares == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	task automatic cfg(input logic r, input logic w, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] wd, input logic ack, input logic [31:0] exp);
		@(posedge clk);
		cfg_req <= '{rd: r, wr: w, addr: a, be: be, wdata: wd};
		@(posedge clk);
		cfg_req <= '0;
		#1;
		chk({31'h0, cfg_ack}, {31'h0, ack});
		chk(cfg_rdata, exp);
	endtask : cfg

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		cfg(1'b1, 1'b0, a, 4'hf, 32'h0, 1'b1, exp);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
		cfg(1'b0, 1'b1, a, be, wd, 1'b1, 32'h0);
	endtask : wr

	task automatic load(input logic [47:0] img, input logic sl);
		@(posedge clk);
		image <= img;
		slow  <= sl;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
	endtask : load

	task automatic wait_loaded;
		repeat (40) if (loaded !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		chk({31'h0, loaded}, 32'h1);
	endtask : wait_loaded

	function automatic logic ea(input logic [3:0] c, input logic r, input logic w,
		input logic mul, input logic dis);
		case (c)
			4'h6: return r;
			4'h7: return w;
			4'hc, 4'he: return mul;
			4'hf: return w & ~dis;
			default: return 1'b0;
		endcase
	endfunction : ea

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	task automatic t_load_refuse;
		load(48'hf5_07_5c_ff_ff_fa, 1'b1);
		cfg(1'b1, 1'b0, 8'h80, 4'hf, 32'h0, 1'b0, 32'h0);
		cfg(1'b0, 1'b1, 8'h74, 4'hf, 32'hffff_ffff, 1'b0, 32'h0);
		wait_loaded();
		rd(8'h80, 32'h0602_0000);
		rd(8'h84, 32'h5c00_0000);
		rd(8'h74, 32'h0000_0506);
	endtask : t_load_refuse

	task automatic t_read_only;
		wr(8'h80, 4'hf, 32'hffff_ffff);
		wr(8'h84, 4'hf, 32'hffff_ffff);
		rd(8'h80, 32'h0602_0000);
		rd(8'h84, 32'h5c00_0000);
		rd(8'h88, 32'h0);
		wr(8'h74, 4'h1, 32'hffff_ffff);
		wr(8'h74, 4'h2, 32'h0);
		wr(8'h74, 4'hc, 32'hffff_ffff);
		rd(8'h74, 32'h0000_00fe);
	endtask : t_read_only

	task automatic t_alias;
		logic [11:0] w [12] = '{12'h002, 12'h004, 12'h008, 12'h010, 12'h020, 12'h040,
			12'h084, 12'h110, 12'h094, 12'h200, 12'h400, 12'h800};
		foreach (w[i]) begin
			wr(8'h74, 4'h3, {20'h0, w[i]});
			chk({21'h0, ctrl}, {21'h0, w[i][11:1]});
			for (int c = 0; c < 16; c++) begin
				@(posedge clk);
				p_cmd <= c[3:0];
				s_cmd <= c[3:0];
				@(posedge clk);
				#1;
				chk({31'h0, p_alias}, {31'h0, ea(c[3:0], w[i][1], w[i][2], w[i][5], w[i][7])});
				chk({31'h0, s_alias}, {31'h0, ea(c[3:0], w[i][3], w[i][4], w[i][6], w[i][8])});
			end
		end
	endtask : t_alias

	task automatic t_reload;
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk({20'h0, ctrl, loaded}, 32'h0);
		load(48'h08_00_a3_00_00_02, 1'b0);
		wait_loaded();
		load(48'hff_ff_ff_ff_ff_ff, 1'b0);
		repeat (10) @(posedge clk);
		rd(8'h80, 32'h0602_0000);
		rd(8'h84, 32'ha300_0000);
		rd(8'h74, 32'h0000_0800);
	endtask : t_reload

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		rst = 1'b1;
		start = 1'b0;
		slow = 1'b0;
		image = '0;
		cfg_req = '0;
		p_cmd = 4'h0;
		s_cmd = 4'h0;
		miscompares = 0;
		checks = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_load_refuse();
		t_read_only();
		t_alias();
		t_reload();
		finish_test();
	end

	// The run needs under 1000 cycles; 4000 cycles leaves ample margin.
	initial begin
		#100000;
		miscompares++;
		finish_test();
	end
endmodule : tb

/* verilog/cmd_alias_decode.sv */
// Alias decision for primary and secondary bus commands.
// Assumes the control fields arrive from the configuration register.
`timescale 1ns/1ps
`include "pm_alias_cfg.svh"

module cmd_alias_decode (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire pm_alias_pkg::ctrl_s  ctrl,
	input  wire logic [3:0]           p_cmd,
	input  wire logic [3:0]           s_cmd,
	output logic                      p_alias,
	output logic                      s_alias
);

	// ------------------------------------------------------------------------
	// Decode shared by both sides
	// ------------------------------------------------------------------------
	// Write-and-invalidate follows the plain write alias unless disabled.
	function automatic logic alias_of(input logic [3:0] cmd, input logic rd_en,
		input logic wr_en, input logic multi_en, input logic inv_dis);
		logic r;
		r = 1'b0;
		unique case (cmd)
			`CMD_MEM_RD:                      r = rd_en;
			`CMD_MEM_WR:                      r = wr_en;
			`CMD_MEM_RD_MULT, `CMD_MEM_RD_LINE: r = multi_en;
			`CMD_MEM_WR_INV:                  r = wr_en & ~inv_dis;
			default:                          r = 1'b0;
		endcase
		return r;
	endfunction : alias_of

	always_ff @(posedge clk) begin
		if (rst) begin
			p_alias <= 1'b0;
		end else begin
			p_alias <= alias_of(p_cmd, ctrl.rd_pri, ctrl.wr_pri,
				ctrl.rd_multi_pri, ctrl.wr_inv_dis_pri); // [R07] [R09] [R10]
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_alias <= 1'b0;
		end else begin
			s_alias <= alias_of(s_cmd, ctrl.rd_sec, ctrl.wr_sec,
				ctrl.rd_multi_sec, ctrl.wr_inv_dis_sec); // [R08] [R09] [R10]
		end
	end

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	property p_pri_alias;
		@(posedge clk) disable iff (rst)
		(p_cmd == `CMD_MEM_RD) |-> ##1 (p_alias == $past(ctrl.rd_pri));
	endproperty
	a_pri_alias: assert property (p_pri_alias) else $error("primary read alias wrong"); // [R07]

	property p_sec_alias;
		@(posedge clk) disable iff (rst)
		(s_cmd == `CMD_MEM_WR) |-> ##1 (s_alias == $past(ctrl.wr_sec));
	endproperty
	a_sec_alias: assert property (p_sec_alias) else $error("secondary write alias wrong"); // [R08]

	property p_multi_alias;
		@(posedge clk) disable iff (rst)
		(s_cmd == `CMD_MEM_RD_LINE && !ctrl.rd_multi_sec) |=> !s_alias;
	endproperty
	a_multi_alias: assert property (p_multi_alias) else $error("read line aliased"); // [R09]

	property p_inv_dis;
		@(posedge clk) disable iff (rst)
		(p_cmd == `CMD_MEM_WR_INV && ctrl.wr_inv_dis_pri) |=> !p_alias;
	endproperty
	a_inv_dis: assert property (p_inv_dis) else $error("disabled write-invalidate aliased"); // [R10]

endmodule : cmd_alias_decode

/* verilog/eeprom_pm_alias_preload.sv */
// Preload of power-management capability, data byte and alias control.
// Assumes a serial reader presents EEPROM bytes with their addresses and
// that configuration cycles arrive as single-cycle request strobes.
//
// Overview of operation
// R01: Capability bits 18:16 read back the version loaded from byte 10 bits 2:0, value 010.
// R02: Capability bit 21 always reads zero, so no special setup is needed.
// R03: Capability bit 25 always reads one to advertise D1 support.
// R04: Capability bit 26 always reads one to advertise D2 support.
// R05: Capability bits 31:27 always read zero since no wake pin exists.
// R06: Byte 13 appears read-only in bits 31:24 of the data register at 84h.
// R07: Control bits 1 and 2 enable aliasing of primary memory reads and writes.
// R08: Control bits 3 and 4 enable aliasing of secondary memory reads and writes.
// R09: Control bits 5 and 6 enable aliasing of read line and multiple per side.
// R10: Control bits 7 and 8 stop aliasing write-and-invalidate per side.
// R11: Control bit 9 keeps the request asserted longer for locked sequences.
// R12: Control bits 10 and 11 make the secondary and primary requests hold longer.
// R13: Bytes load after reset, reserved bytes are dropped and reserved bits read zero.
`timescale 1ns/1ps
`include "pm_alias_cfg.svh"

module eeprom_pm_alias_preload (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   ee_valid,
	input  wire logic [7:0]             ee_addr,
	input  wire logic [7:0]             ee_data,
	input  wire logic                   ee_done,
	input  wire pm_alias_pkg::cfg_req_s cfg_req,
	output logic [31:0]                 cfg_rdata,
	output logic                        cfg_ack,
	input  wire logic [3:0]             p_cmd,
	input  wire logic [3:0]             s_cmd,
	output logic                        p_alias,
	output logic                        s_alias,
	output pm_alias_pkg::ctrl_s         ctrl,
	output logic                        loaded
);

	// ------------------------------------------------------------------------
	// Load sequencing
	// ------------------------------------------------------------------------
	pm_alias_pkg::load_state_e state;
	logic [2:0]                pm_ver;
	logic [7:0]                pm_data;
	logic                      in_load;
	logic                      cfg_ok;
	logic                      wr_ctrl;
	logic [15:0]               ctrl_word;

	assign in_load   = (state == pm_alias_pkg::ST_LOAD);
	assign cfg_ok    = (state == pm_alias_pkg::ST_READY);
	assign wr_ctrl   = cfg_ok & cfg_req.wr & (cfg_req.addr == `OFS_ALIAS_CTRL);
	assign ctrl_word = {4'h0, ctrl, 1'b0};

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= pm_alias_pkg::ST_LOAD;
		end else begin
			unique case (state)
				pm_alias_pkg::ST_LOAD:  if (ee_done) begin
					state <= pm_alias_pkg::ST_READY; // [R13]
				end
				pm_alias_pkg::ST_READY: state <= pm_alias_pkg::ST_READY;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			loaded <= 1'b0;
		end else begin
			loaded <= cfg_ok | (in_load & ee_done);
		end
	end

	// ------------------------------------------------------------------------
	// Preloaded read-only fields
	// ------------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			pm_ver <= `RST_PM_VER;
		end else if (in_load && ee_valid && ee_addr == `EE_PM_CAP_LO) begin
			pm_ver <= ee_data[2:0]; // [R01]
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pm_data <= `RST_PM_DATA;
		end else if (in_load && ee_valid && ee_addr == `EE_PM_DATA) begin
			pm_data <= ee_data; // [R06]
		end
	end

	// ------------------------------------------------------------------------
	// Alias and request-hold control register
	// ------------------------------------------------------------------------
	// Loading and configuration writes never overlap, since requests are
	// only taken once the load has finished.
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl <= `RST_CTRL;
		end else if (in_load && ee_valid && ee_addr == `EE_CTRL_LO) begin
			ctrl[6:0] <= ee_data[7:1]; // [R13]
		end else if (in_load && ee_valid && ee_addr == `EE_CTRL_HI) begin
			ctrl[10:7] <= ee_data[3:0]; // [R11] [R12]
		end else if (wr_ctrl) begin
			if (cfg_req.be[0]) begin
				ctrl[6:0] <= cfg_req.wdata[7:1]; // [R07] [R08] [R09]
			end
			if (cfg_req.be[1]) begin
				ctrl[10:7] <= cfg_req.wdata[11:8]; // [R10] [R11] [R12]
			end
		end
	end

	// ------------------------------------------------------------------------
	// Configuration read path
	// ------------------------------------------------------------------------
	function automatic logic [31:0] read_word(input logic [7:0] a);
		logic [31:0] w;
		w = 32'h0000_0000;
		unique case (a)
			`OFS_PM_CAP: begin
				w[`CAP_VER_MSB:`CAP_VER_LSB] = pm_ver; // [R01]
				w[`CAP_DSI_BIT]              = 1'b0;   // [R02]
				w[`CAP_D1_BIT]               = 1'b1;   // [R03]
				w[`CAP_D2_BIT]               = 1'b1;   // [R04]
				w[`CAP_PME_MSB:`CAP_PME_LSB] = 5'h00;  // [R05]
			end
			`OFS_PM_DATA:    w[`DATA_MSB:`DATA_LSB] = pm_data; // [R06]
			`OFS_ALIAS_CTRL: w[15:0] = ctrl_word; // [R13]
			default:         w = 32'h0000_0000;
		endcase
		return w;
	endfunction : read_word

	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_ack <= 1'b0;
		end else begin
			cfg_ack <= cfg_ok & (cfg_req.rd | cfg_req.wr);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_rdata <= 32'h0000_0000;
		end else if (cfg_ok && cfg_req.rd) begin
			cfg_rdata <= read_word(cfg_req.addr);
		end else begin
			cfg_rdata <= 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------------------
	// Command alias decode
	// ------------------------------------------------------------------------
	cmd_alias_decode u_alias (
		.clk     (clk),
		.rst     (rst),
		.ctrl    (ctrl),
		.p_cmd   (p_cmd),
		.s_cmd   (s_cmd),
		.p_alias (p_alias),
		.s_alias (s_alias)
	);

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	sequence s_cap_read;
		cfg_ok && cfg_req.rd && cfg_req.addr == `OFS_PM_CAP;
	endsequence

	sequence s_data_read;
		cfg_ok && cfg_req.rd && cfg_req.addr == `OFS_PM_DATA;
	endsequence

	property p_ver;
		@(posedge clk) disable iff (rst)
		s_cap_read |=> cfg_ack && cfg_rdata[18:16] == $past(pm_ver);
	endproperty
	a_ver: assert property (p_ver) else $error("version field wrong"); // [R01]

	property p_dsi;
		@(posedge clk) disable iff (rst)
		s_cap_read |=> cfg_ack && !cfg_rdata[21];
	endproperty
	a_dsi: assert property (p_dsi) else $error("setup bit not zero"); // [R02]

	property p_d1;
		@(posedge clk) disable iff (rst)
		s_cap_read |=> cfg_rdata[25];
	endproperty
	a_d1: assert property (p_d1) else $error("D1 support bit not one"); // [R03]

	property p_d2;
		@(posedge clk) disable iff (rst)
		s_cap_read |=> cfg_rdata[26];
	endproperty
	a_d2: assert property (p_d2) else $error("D2 support bit not one"); // [R04]

	property p_pme;
		@(posedge clk) disable iff (rst)
		s_cap_read |=> cfg_rdata[31:27] == 5'h00;
	endproperty
	a_pme: assert property (p_pme) else $error("wake support field not zero"); // [R05]

	property p_data;
		@(posedge clk) disable iff (rst)
		(in_load && ee_valid && ee_addr == `EE_PM_DATA) |=> pm_data == $past(ee_data);
	endproperty
	a_data: assert property (p_data) else $error("data byte not loaded"); // [R06]

	property p_data_read;
		@(posedge clk) disable iff (rst)
		s_data_read |=> cfg_ack && cfg_rdata == {$past(pm_data), 24'h000000};
	endproperty
	a_data_read: assert property (p_data_read) else $error("data byte not exposed"); // [R06]

	property p_hold;
		@(posedge clk) disable iff (rst)
		(wr_ctrl && cfg_req.be[1]) |=> ctrl.hold_pri == $past(cfg_req.wdata[11])
			&& ctrl.hold_sec == $past(cfg_req.wdata[10])
			&& ctrl.long_lock_req == $past(cfg_req.wdata[9]);
	endproperty
	a_hold: assert property (p_hold) else $error("hold bits not written"); // [R11] [R12]

	property p_reserved;
		@(posedge clk) disable iff (rst)
		(cfg_ok && cfg_req.rd && cfg_req.addr == `OFS_ALIAS_CTRL)
		|=> !cfg_rdata[0] && cfg_rdata[31:12] == 20'h00000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // [R13]

	property p_no_ack_in_load;
		@(posedge clk) disable iff (rst)
		in_load |=> !cfg_ack;
	endproperty
	a_no_ack_in_load: assert property (p_no_ack_in_load) else $error("ack during load"); // [R13]

endmodule : eeprom_pm_alias_preload
